// File: hs_channel_control_pkg.sv
// shared constants and carriers for the high-speed channel control register slice
package hs_channel_control_pkg;

  // clause 22 frame shape
  localparam int unsigned PREAMBLE_ONES = 32;
  localparam int unsigned HEADER_BITS = 12;
  localparam int unsigned DATA_BITS = 16;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // direct register offsets
  localparam logic [4:0] ADDR_HS_CHANNEL_CONTROL = 5'h1d;
  localparam logic [4:0] ADDR_EXTENDED_POINTER = 5'h1e;
  localparam logic [4:0] ADDR_EXTENDED_DATA = 5'h1f;

  // extended register offsets
  localparam logic [15:0] EXT_TX_SEARCH = 16'h8000;
  localparam logic [15:0] EXT_TX_REPLACE = 16'h8001;
  localparam logic [15:0] EXT_RX_SEARCH = 16'h8002;
  localparam logic [15:0] EXT_RX_REPLACE = 16'h8003;

  // reset values
  localparam logic [15:0] HS_CONTROL_RESET = 16'h0880;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [9:0] TX_SEARCH_RESET = 10'h2bc;
  localparam logic [9:0] TX_REPLACE_RESET = 10'h27c;
  localparam logic [9:0] RX_SEARCH_RESET = 10'h27c;
  localparam logic [9:0] RX_REPLACE_RESET = 10'h2bc;

  // field positions in hs_channel_control
  localparam int unsigned BIT_SELF_CLEAR = 15;
  localparam int unsigned RX_DEPTH_MSB = 14;
  localparam int unsigned RX_DEPTH_LSB = 12;
  localparam int unsigned BIT_RX_MARKER = 11;
  localparam int unsigned TX_DEPTH_MSB = 10;
  localparam int unsigned TX_DEPTH_LSB = 8;
  localparam int unsigned BIT_TX_MARKER = 7;
  localparam int unsigned BIT_FORCE_ALIGN = 5;
  localparam int unsigned BIT_JOG = 4;
  localparam int unsigned BIT_ENC_SKIP = 3;
  localparam int unsigned BIT_DEC_SKIP = 2;
  localparam int unsigned POLICY_MSB = 1;
  localparam int unsigned POLICY_LSB = 0;

  // sync-loss policy codes and limits, forced alignment position
  localparam logic [1:0] POLICY_STANDARD = 2'h0;
  localparam logic [1:0] POLICY_ONE = 2'h1;
  localparam logic [1:0] POLICY_TWO = 2'h2;
  localparam logic [1:0] POLICY_THREE = 2'h3;
  localparam logic [2:0] STANDARD_ERROR_LIMIT = 3'h4;
  localparam logic [1:0] STANDARD_GOOD_RUN = 2'h3;
  localparam logic [3:0] FORCED_ALIGNMENT = 4'h9;

  typedef struct packed {
    logic [2:0] fast_rx_fifo_depth;
    logic [2:0] fast_tx_fifo_depth;
    logic rx_marker_enable;
    logic tx_marker_enable;
    logic forced_byte_alignment;
    logic manual_alignment_jog;
    logic fast_encoder_skip;
    logic fast_decoder_skip;
    logic [1:0] sync_loss_policy;
  } hs_control_s;

  typedef struct packed {
    logic [9:0] tx_search;
    logic [9:0] tx_replace;
    logic [9:0] rx_search;
    logic [9:0] rx_replace;
  } marker_chars_s;

endpackage

// File: hs_channel_control_regs.sv
// clause 22 management slave with high-speed channel control, extended window and markers
`timescale 1ns/1ps
`default_nettype none

module hs_channel_control_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_address,
  input wire logic rx_code_valid,
  input wire logic rx_code_error,
  input wire logic rx_comma_seen,
  output logic rx_synced,
  input wire logic [3:0] auto_alignment,
  input wire logic [3:0] jog_alignment,
  output logic [3:0] alignment_position,
  input wire logic [9:0] tx_char_in,
  output logic [9:0] tx_char_out,
  input wire logic [9:0] rx_char_in,
  output logic [9:0] rx_char_out,
  output hs_channel_control_pkg::hs_control_s control
);

  typedef enum logic [2:0] {
    st_preamble,
    st_start,
    st_header,
    st_turn,
    st_write_data,
    st_read_data
  } mdio_state_e;

  // pin synchronisers; first stages feed only the second
  logic mdc_meta, mdc_sync, mdc_last;
  logic mdio_meta, mdio_sync;
  logic [4:0] phy_meta, phy_sync;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mdc_meta <= 1'b0;
      mdc_sync <= 1'b0;
      mdc_last <= 1'b0;
      mdio_meta <= 1'b1;
      mdio_sync <= 1'b1;
      phy_meta <= 5'h00;
      phy_sync <= 5'h00;
    end else if (ce) begin
      mdc_meta <= mdc;
      mdc_sync <= mdc_meta;
      mdc_last <= mdc_sync;
      mdio_meta <= mdio_in;
      mdio_sync <= mdio_meta;
      phy_meta <= phy_address;
      phy_sync <= phy_meta;
    end
  end

  logic mdc_rise;
  assign mdc_rise = mdc_sync & ~mdc_last;

  // frame engine
  mdio_state_e state;
  logic [5:0] ones;
  logic [4:0] bit_count;
  logic [11:0] header;
  logic [15:0] shifter;
  logic write_strobe;
  logic [4:0] access_reg;
  logic header_done, header_match;
  logic [11:0] full_header;

  assign full_header = {header[10:0], mdio_sync};
  assign header_done = (bit_count == 5'(hs_channel_control_pkg::HEADER_BITS - 1));
  assign header_match = (full_header[9:5] == phy_sync);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= st_preamble;
      ones <= 6'h00;
      bit_count <= 5'h00;
      header <= 12'h000;
      shifter <= 16'h0000;
      write_strobe <= 1'b0;
      access_reg <= 5'h00;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (ce) begin
      write_strobe <= 1'b0;
      if (mdc_rise) begin
        case (state)
          st_preamble: begin
            if (mdio_sync) begin
              if (ones != 6'(hs_channel_control_pkg::PREAMBLE_ONES)) begin
                ones <= ones + 6'h01;
              end
            end else if (ones == 6'(hs_channel_control_pkg::PREAMBLE_ONES)) begin
              state <= st_start;
            end else begin
              ones <= 6'h00;
            end
          end
          st_start: begin
            ones <= 6'h00;
            bit_count <= 5'h00;
            state <= mdio_sync ? st_header : st_preamble;
          end
          st_header: begin
            header <= full_header;
            bit_count <= bit_count + 5'h01;
            if (header_done) begin
              bit_count <= 5'h00;
              access_reg <= full_header[4:0];
              if (!header_match) begin
                state <= st_preamble;
              end else if (full_header[11:10] == hs_channel_control_pkg::OP_READ) begin
                shifter <= read_value_for(full_header[4:0]);
                state <= st_turn;
              end else if (full_header[11:10] == hs_channel_control_pkg::OP_WRITE) begin
                state <= st_turn;
              end else begin
                state <= st_preamble;
              end
            end
          end
          st_turn: begin
            // first turnaround slot left undriven, second driven low on reads
            bit_count <= bit_count + 5'h01;
            if (header[11:10] == hs_channel_control_pkg::OP_READ) begin
              mdio_oe <= 1'b1;
              mdio_out <= 1'b0;
              bit_count <= 5'h00;
              state <= st_read_data;
            end else if (bit_count == 5'h01) begin
              bit_count <= 5'h00;
              state <= st_write_data;
            end
          end
          st_write_data: begin
            shifter <= {shifter[14:0], mdio_sync};
            bit_count <= bit_count + 5'h01;
            if (bit_count == 5'(hs_channel_control_pkg::DATA_BITS - 1)) begin
              write_strobe <= 1'b1;
              state <= st_preamble;
            end
          end
          st_read_data: begin
            bit_count <= bit_count + 5'h01;
            if (bit_count == 5'(hs_channel_control_pkg::DATA_BITS)) begin
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              state <= st_preamble;
            end else begin
              mdio_out <= shifter[15];
              shifter <= {shifter[14:0], 1'b0};
            end
          end
          default: state <= st_preamble;
        endcase
      end
    end
  end

  // register store
  logic [15:0] hs_channel_control;
  logic [15:0] extended_address_pointer;
  logic [9:0] tx_marker_search_char, tx_marker_replace_char;
  logic [9:0] rx_marker_search_char, rx_marker_replace_char;

  function automatic logic [15:0] ext_value(input logic [15:0] ptr);
    logic [15:0] v;
    v = 16'h0000;
    if (ptr == hs_channel_control_pkg::EXT_TX_SEARCH) begin
      v = {6'h00, tx_marker_search_char};
    end else if (ptr == hs_channel_control_pkg::EXT_TX_REPLACE) begin
      v = {6'h00, tx_marker_replace_char};
    end else if (ptr == hs_channel_control_pkg::EXT_RX_SEARCH) begin
      v = {6'h00, rx_marker_search_char};
    end else if (ptr == hs_channel_control_pkg::EXT_RX_REPLACE) begin
      v = {6'h00, rx_marker_replace_char};
    end
    return v;
  endfunction

  function automatic logic [15:0] read_value_for(input logic [4:0] regad);
    logic [15:0] v;
    v = 16'h0000;
    if (regad == hs_channel_control_pkg::ADDR_HS_CHANNEL_CONTROL) begin
      v = hs_channel_control;
    end else if (regad == hs_channel_control_pkg::ADDR_EXTENDED_POINTER) begin
      v = extended_address_pointer;
    end else if (regad == hs_channel_control_pkg::ADDR_EXTENDED_DATA) begin
      v = ext_value(extended_address_pointer);
    end
    return v;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hs_channel_control <= hs_channel_control_pkg::HS_CONTROL_RESET;
      extended_address_pointer <= hs_channel_control_pkg::POINTER_RESET;
      tx_marker_search_char <= hs_channel_control_pkg::TX_SEARCH_RESET;
      tx_marker_replace_char <= hs_channel_control_pkg::TX_REPLACE_RESET;
      rx_marker_search_char <= hs_channel_control_pkg::RX_SEARCH_RESET;
      rx_marker_replace_char <= hs_channel_control_pkg::RX_REPLACE_RESET;
    end else if (ce) begin
      // self-clearing reserved bit never holds for more than one cycle
      hs_channel_control[hs_channel_control_pkg::BIT_SELF_CLEAR] <= 1'b0;
      if (write_strobe) begin
        if (access_reg == hs_channel_control_pkg::ADDR_HS_CHANNEL_CONTROL) begin
          hs_channel_control <= shifter;
        end else if (access_reg == hs_channel_control_pkg::ADDR_EXTENDED_POINTER) begin
          extended_address_pointer <= shifter;
        end else if (access_reg == hs_channel_control_pkg::ADDR_EXTENDED_DATA) begin
          if (extended_address_pointer == hs_channel_control_pkg::EXT_TX_SEARCH) begin
            tx_marker_search_char <= shifter[9:0];
          end else if (extended_address_pointer == hs_channel_control_pkg::EXT_TX_REPLACE) begin
            tx_marker_replace_char <= shifter[9:0];
          end else if (extended_address_pointer == hs_channel_control_pkg::EXT_RX_SEARCH) begin
            rx_marker_search_char <= shifter[9:0];
          end else if (extended_address_pointer == hs_channel_control_pkg::EXT_RX_REPLACE) begin
            rx_marker_replace_char <= shifter[9:0];
          end
        end
      end
    end
  end

  assign control.fast_rx_fifo_depth =
    hs_channel_control[hs_channel_control_pkg::RX_DEPTH_MSB:hs_channel_control_pkg::RX_DEPTH_LSB];
  assign control.fast_tx_fifo_depth =
    hs_channel_control[hs_channel_control_pkg::TX_DEPTH_MSB:hs_channel_control_pkg::TX_DEPTH_LSB];
  assign control.rx_marker_enable = hs_channel_control[hs_channel_control_pkg::BIT_RX_MARKER];
  assign control.tx_marker_enable = hs_channel_control[hs_channel_control_pkg::BIT_TX_MARKER];
  assign control.forced_byte_alignment = hs_channel_control[hs_channel_control_pkg::BIT_FORCE_ALIGN];
  assign control.manual_alignment_jog = hs_channel_control[hs_channel_control_pkg::BIT_JOG];
  assign control.fast_encoder_skip = hs_channel_control[hs_channel_control_pkg::BIT_ENC_SKIP];
  assign control.fast_decoder_skip = hs_channel_control[hs_channel_control_pkg::BIT_DEC_SKIP];
  assign control.sync_loss_policy =
    hs_channel_control[hs_channel_control_pkg::POLICY_MSB:hs_channel_control_pkg::POLICY_LSB];

  // byte alignment select
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alignment_position <= 4'h0;
    end else if (ce) begin
      if (control.manual_alignment_jog) begin
        alignment_position <= jog_alignment;
      end else if (control.forced_byte_alignment) begin
        alignment_position <= hs_channel_control_pkg::FORCED_ALIGNMENT;
      end else begin
        alignment_position <= auto_alignment;
      end
    end
  end

  // marker search and replace, one register stage each way
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_char_out <= 10'h000;
      rx_char_out <= 10'h000;
    end else if (ce) begin
      if (control.tx_marker_enable && tx_char_in == tx_marker_search_char) begin
        tx_char_out <= tx_marker_replace_char;
      end else begin
        tx_char_out <= tx_char_in;
      end
      if (control.rx_marker_enable && rx_char_in == rx_marker_search_char) begin
        rx_char_out <= rx_marker_replace_char;
      end else begin
        rx_char_out <= rx_char_in;
      end
    end
  end

  // sync-loss machine; standard policy counts errors back down after good runs
  logic [2:0] error_count;
  logic [1:0] good_run;
  logic [2:0] next_error_count;
  logic drop_sync;

  always_comb begin
    next_error_count = error_count;
    drop_sync = 1'b0;
    if (rx_code_valid && rx_code_error) begin
      next_error_count = error_count + 3'h1;
      // at-or-above, so a count left over from another policy still drops
      case (control.sync_loss_policy)
        hs_channel_control_pkg::POLICY_STANDARD: begin
          drop_sync = (next_error_count >= hs_channel_control_pkg::STANDARD_ERROR_LIMIT);
        end
        hs_channel_control_pkg::POLICY_ONE: drop_sync = 1'b1;
        hs_channel_control_pkg::POLICY_TWO: drop_sync = (next_error_count >= 3'h2);
        hs_channel_control_pkg::POLICY_THREE: drop_sync = (next_error_count >= 3'h3);
        default: drop_sync = 1'b1;
      endcase
    end else if (rx_code_valid) begin
      if (control.sync_loss_policy != hs_channel_control_pkg::POLICY_STANDARD) begin
        next_error_count = 3'h0; // adjacency broken by a good code
      end else if (good_run == hs_channel_control_pkg::STANDARD_GOOD_RUN && error_count != 3'h0) begin
        next_error_count = error_count - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_synced <= 1'b0;
      error_count <= 3'h0;
      good_run <= 2'h0;
    end else if (ce) begin
      if (!rx_synced) begin
        error_count <= 3'h0;
        good_run <= 2'h0;
        rx_synced <= rx_comma_seen;
      end else if (drop_sync) begin
        rx_synced <= 1'b0;
        error_count <= 3'h0;
        good_run <= 2'h0;
      end else if (rx_code_valid) begin
        error_count <= next_error_count;
        good_run <= (rx_code_error || good_run == hs_channel_control_pkg::STANDARD_GOOD_RUN) ? 2'h0 : good_run + 2'h1;
      end
    end
  end

endmodule // hs_channel_control_regs

`default_nettype wire

// File: hs_channel_control_regs_properties.sv
// concurrent checks on the port behaviour of the channel control slice
`timescale 1ns/1ps
`default_nettype none
module hs_channel_control_regs_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic rx_code_valid,
  input wire logic rx_code_error,
  input wire logic rx_comma_seen,
  input wire logic rx_synced,
  input wire logic [3:0] auto_alignment,
  input wire logic [3:0] jog_alignment,
  input wire logic [3:0] alignment_position,
  input wire logic [9:0] tx_char_in,
  input wire logic [9:0] tx_char_out,
  input wire logic [9:0] rx_char_in,
  input wire logic [9:0] rx_char_out,
  input wire hs_channel_control_pkg::hs_control_s control
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_tx_pass;
    !control.tx_marker_enable |=> tx_char_out == $past(tx_char_in);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx char altered while marker off");
  property p_rx_pass;
    !control.rx_marker_enable |=> rx_char_out == $past(rx_char_in);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx char altered while marker off");
  property p_jog;
    control.manual_alignment_jog |=> alignment_position == $past(jog_alignment);
  endproperty
  a_jog: assert property (p_jog) else $error("jog position not applied");
  property p_forced;
    control.forced_byte_alignment && !control.manual_alignment_jog |=> alignment_position == 4'h9;
  endproperty
  a_forced: assert property (p_forced) else $error("forced position not nine");
  property p_auto;
    !control.forced_byte_alignment && !control.manual_alignment_jog |=> alignment_position == $past(auto_alignment);
  endproperty
  a_auto: assert property (p_auto) else $error("automatic position not followed");
  // comma excluded: it legally resynchronises during an error burst
  property p_one;
    control.sync_loss_policy == 2'h1 && rx_code_valid && rx_code_error && !rx_comma_seen |=> !rx_synced;
  endproperty
  a_one: assert property (p_one) else $error("single error kept sync");
  property p_two;
    (control.sync_loss_policy == 2'h2 && rx_code_valid && rx_code_error && !rx_comma_seen)[*2] |=> !rx_synced;
  endproperty
  a_two: assert property (p_two) else $error("two errors kept sync");
  property p_three;
    (control.sync_loss_policy == 2'h3 && rx_code_valid && rx_code_error && !rx_comma_seen)[*3] |=> !rx_synced;
  endproperty
  a_three: assert property (p_three) else $error("three errors kept sync");
  property p_three_hold;
    (rx_synced && control.sync_loss_policy == 2'h3 && rx_code_valid && !rx_code_error)
      ##1 (control.sync_loss_policy == 2'h3 && rx_code_valid && rx_code_error)[*2] |=> rx_synced;
  endproperty
  a_three_hold: assert property (p_three_hold) else $error("sync lost after two errors");
  property p_turn;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround bit not low");
endmodule // hs_channel_control_regs_properties
bind hs_channel_control_regs hs_channel_control_regs_properties i_hs_channel_control_regs_properties (
  .ref_clk, .reset, .mdio_out, .mdio_oe, .rx_code_valid, .rx_code_error, .rx_comma_seen, .rx_synced,
  .auto_alignment, .jog_alignment, .alignment_position, .tx_char_in, .tx_char_out, .rx_char_in,
  .rx_char_out, .control
);
`default_nettype wire

// File: mdio_station.sv
// management station model driving the mdc and mdio pins
`timescale 1ns/1ps
`default_nettype none
module mdio_station (
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  localparam logic [4:0] PHY = 5'h05;
  logic drv = 1'b1;
  logic smp;
  initial mdc = 1'b0;
  // released line reads the station's drv level, which is high through read turnaround and data
  assign mdio_in = (mdio_oe === 1'b1) ? mdio_out : drv;

  task automatic tick(input logic b);
    drv = b;
    #62.5 mdc = 1'b1;
    smp = mdio_in;
    #62.5 mdc = 1'b0;
  endtask
  // clock stands low between frames; odd offset keeps edges off ref_clk
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [47:0] f;
    rd = 16'h0000;
    #1.1;
    f = {32'hffffffff, 2'b01, op, PHY, ra, (op == hs_channel_control_pkg::OP_WRITE) ? 2'b10 : 2'b11};
    for (int i = 47; i >= 0; i--) tick(f[i]);
    if (op == hs_channel_control_pkg::OP_WRITE) begin
      for (int i = 15; i >= 0; i--) tick(wd[i]);
    end else begin
      // first data bit stands at the rise after the second turnaround slot
      for (int i = 15; i >= 0; i--) begin
        tick(1'b1);
        rd[i] = smp;
      end
      tick(1'b1);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    xfer(hs_channel_control_pkg::OP_WRITE, a, d, x);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    xfer(hs_channel_control_pkg::OP_READ, a, 16'h0000, d);
  endtask
  task automatic ext_wr(input logic [15:0] a, input logic [15:0] d);
    wr(5'h1e, a);
    wr(5'h1f, d);
  endtask
  task automatic ext_rd(input logic [15:0] a, output logic [15:0] d);
    wr(5'h1e, a);
    rd(5'h1f, d);
  endtask
endmodule // mdio_station
`default_nettype wire

// File: testbench.sv
// self-checking bench for the channel control register slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, mdc, mdio_in, mdio_out, mdio_oe, rx_synced;
  logic rx_code_valid = 1'b0, rx_code_error = 1'b0, rx_comma_seen = 1'b0;
  logic [3:0] auto_alignment = 4'h0, jog_alignment = 4'h0, alignment_position;
  logic [9:0] tx_char_in = 10'h000, rx_char_in = 10'h000, tx_char_out, rx_char_out;
  hs_channel_control_pkg::hs_control_s control;
  int fails = 0, n_checks = 0;
  logic [15:0] rd;

  hs_channel_control_regs i_hs_channel_control_regs (
    .ref_clk, .reset, .ce(1'b1), .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_address(5'h05),
    .rx_code_valid, .rx_code_error, .rx_comma_seen, .rx_synced, .auto_alignment, .jog_alignment,
    .alignment_position, .tx_char_in, .tx_char_out, .rx_char_in, .rx_char_out, .control
  );
  mdio_station i_mdio_station (.mdio_out, .mdio_oe, .mdc, .mdio_in);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // register bits rearranged into the field order of the control carrier
  function automatic logic [13:0] ctl(input logic [15:0] r);
    return {r[14:12], r[10:8], r[11], r[7], r[5:2], r[1:0]};
  endfunction
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    i_mdio_station.rd(a, rd);
    check(rd, e);
  endtask
  task automatic ext_chk(input logic [15:0] a, input logic [15:0] e);
    i_mdio_station.ext_rd(a, rd);
    check(rd, e);
  endtask
  task automatic chars(input logic [9:0] t, input logic [9:0] r, input logic [9:0] et, input logic [9:0] er);
    @(negedge ref_clk) {tx_char_in, rx_char_in} = {t, r};
    @(negedge ref_clk);
    check(tx_char_out, et);
    check(rx_char_out, er);
  endtask

  task automatic t_reset;
    check(control, ctl(16'h0880));
    rdchk(5'h1d, 16'h0880);
    rdchk(5'h1e, 16'h0000);
    ext_chk(16'h8000, 16'h02bc);
    ext_chk(16'h8001, 16'h027c);
    ext_chk(16'h8002, 16'h027c);
    ext_chk(16'h8003, 16'h02bc);
    $display("reset test done");
  endtask
  task automatic t_ctrl;
    logic [15:0] v [4] = '{16'h7fbc, 16'h1229, 16'h6a16, 16'h45b3};
    foreach (v[i]) begin
      i_mdio_station.wr(5'h1d, v[i]);
      check(control, ctl(v[i]));
      rdchk(5'h1d, v[i]);
    end
    $display("control test done");
  endtask
  task automatic t_sync;
    for (int p = 0; p < 4; p++) begin
      i_mdio_station.wr(5'h1d, {14'h0220, p[1:0]});
      @(negedge ref_clk) rx_comma_seen = 1'b1;
      @(negedge ref_clk) {rx_comma_seen, rx_code_valid, rx_code_error} = 3'b010;
      // standard policy without good runs needs four errors net
      for (int k = 1; k <= ((p == 0) ? 4 : p); k++) begin
        @(negedge ref_clk);
        check(rx_synced, 1'b1);
        {rx_code_valid, rx_code_error} = 2'b11;
      end
      @(negedge ref_clk) {rx_code_valid, rx_code_error} = 2'b00;
      check(rx_synced, 1'b0);
    end
    $display("sync test done");
  endtask
  task automatic t_align;
    logic [15:0] v [3] = '{16'h08a0, 16'h08b0, 16'h0880};
    logic [3:0] e [3] = '{4'h9, 4'h6, 4'h3};
    @(negedge ref_clk) {auto_alignment, jog_alignment} = 8'h36;
    foreach (v[i]) begin
      i_mdio_station.wr(5'h1d, v[i]);
      repeat (2) @(negedge ref_clk);
      check(alignment_position, e[i]);
    end
    $display("alignment test done");
  endtask
  task automatic t_chars;
    i_mdio_station.ext_wr(16'h8000, 16'hfd55);
    i_mdio_station.ext_wr(16'h8001, 16'h00aa);
    i_mdio_station.ext_wr(16'h8002, 16'h0333);
    i_mdio_station.ext_wr(16'h8003, 16'h00cc);
    rdchk(5'h1e, 16'h8003);
    rdchk(5'h1f, 16'h00cc);
    rdchk(5'h1f, 16'h00cc);
    ext_chk(16'h8000, 16'h0155);
    ext_chk(16'h8004, 16'h0000);
    chars(10'h155, 10'h333, 10'h0aa, 10'h0cc);
    chars(10'h154, 10'h332, 10'h154, 10'h332);
    i_mdio_station.wr(5'h1d, 16'h0000);
    chars(10'h155, 10'h333, 10'h155, 10'h333);
    $display("marker test done");
  endtask
  // three errors, four good codes pay one back, so the next error keeps sync
  task automatic t_hyst;
    logic [1:0] seq [9] = '{2'b11, 2'b11, 2'b11, 2'b10, 2'b10, 2'b10, 2'b10, 2'b11, 2'b00};
    @(negedge ref_clk) rx_comma_seen = 1'b1;
    foreach (seq[i]) begin
      @(negedge ref_clk) {rx_comma_seen, rx_code_valid, rx_code_error} = {1'b0, seq[i]};
    end
    check(rx_synced, 1'b1);
    @(negedge ref_clk) {rx_code_valid, rx_code_error} = 2'b11;
    @(negedge ref_clk) {rx_code_valid, rx_code_error} = 2'b00;
    check(rx_synced, 1'b0);
    $display("hysteresis test done");
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    // synchronisers settle before any pin activity
    repeat (4) @(negedge ref_clk);
    t_reset;
    t_ctrl;
    t_sync;
    t_align;
    t_chars;
    t_hyst;
    conclude;
  end
  initial begin
    #600us;
    fails++;
    conclude;
  end
endmodule // testbench
`default_nettype wire
